/* core/csc_defs.vh */
// Purpose: constants for the capacitive sense control block
// Assumes: byte offsets on a 32-bit APB bus, one register per word
// Notes:   offsets are local choices; no offsets are printed
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

`define CSC_OFS_MAIN        12'h000
`define CSC_OFS_CHAN        12'h004

`define CSC_BIT_ENABLE      7
`define CSC_BIT_REFMODE     6
`define CSC_RANGE_HI        3
`define CSC_RANGE_LO        2
`define CSC_BIT_DIR         1
`define CSC_BIT_T0XSRC      0

`define CSC_MAIN_RESET      8'h00
`define CSC_CHAN_RESET      4'h0
`define CSC_MAIN_WMASK      8'hCD

`define CSC_CHAN_LAST       4'hB
`define CSC_CHAN_LAST_SMALL 4'h7
`define CSC_NUM_CHAN        12

`define CSC_RANGE_OFF       2'h0
`define CSC_RANGE_LOW       2'h1
`define CSC_RANGE_MED       2'h2
`define CSC_RANGE_HIGH      2'h3

`define CSC_SYNC_STAGES     2

`endif

/* core/csc_sync.v */
// Purpose: two-flop synchroniser for one level from outside the clock
// Assumes: input is a slow level or an asynchronous pin
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`include "csc_defs.vh"

module csc_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire async_in,
  output wire sync_out
);

  reg meta_q;
  reg sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // csc_sync

/* core/csc_chan_decode.v */
// Purpose: one-hot sense channel connect from the channel code
// Assumes: code is registered in the caller
// Notes:   reserved codes and absent channels connect nothing
`timescale 1ns/1ps
`include "csc_defs.vh"

module csc_chan_decode (
  input  wire                     enable,
  input  wire                     large_pkg,
  input  wire [3:0]               code,
  output wire [`CSC_NUM_CHAN-1:0] connect
);

  wire [3:0] last;

  // small package tops out at channel 7
  assign last = large_pkg ? `CSC_CHAN_LAST : `CSC_CHAN_LAST_SMALL;

  genvar i;
  generate
    for (i = 0; i < `CSC_NUM_CHAN; i = i + 1) begin : g_ch
      // compared at full integer width, so nothing is cut
      assign connect[i] = enable && (code <= last) &&
                          ({28'h0000000, code} == i);
    end
  endgenerate

endmodule // csc_chan_decode

/* core/csc_top.v */
// Purpose: control and status registers of the capacitive sense block
// Assumes: APB slave on pclk; oscillator direction arrives asynchronously
// Notes:   analog oscillator and timer counters live outside this block
//
// What this block does
// RULE1 - block runs only while enable bit set
// RULE2 - reference mode bit picks variable or fixed
// RULE3 - fixed mode range 00 stops the oscillator
// RULE4 - variable mode range 00 is noise detection
// RULE5 - variable mode ranges 01-11 low, medium, high
// RULE6 - status bit one reads oscillator direction
// RULE7 - ext select picks oscillator or clock pin
// RULE8 - timer clock select low gives fosc/4
// RULE9 - disabled block connects no sense channel
// RULE10 - enabled, channel code picks matching input
// RULE11 - software avoids reserved channel codes
// RULE12 - channels eight to eleven only on large package
// RULE13 - channel register upper nibble reads zero
// RULE14 - channel bits reset to zero on reset
// RULE15 - writes to direction status bit are ignored
`timescale 1ns/1ps
`include "csc_defs.vh"

module csc_top (
  input  wire                     pclk,
  input  wire                     presetn,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [11:0]              paddr,
  input  wire [31:0]              pwdata,
  input  wire [3:0]               pstrb,
  output wire                     pready,
  output reg  [31:0]              prdata,
  output wire                     pslverr,
  input  wire                     large_pkg,
  input  wire                     osc_sourcing,
  input  wire                     timer0_clock_select,
  input  wire                     timer0_ext_clock_pin,
  input  wire                     sense_osc_clk,
  input  wire                     fosc_div4_clk,
  output wire                     sense_enable,
  output wire                     reference_mode_select,
  output wire                     osc_run,
  output wire                     noise_detect,
  output wire [1:0]               current_range,
  output wire                     charge_current_on,
  output wire                     timer0_ext_source_select,
  output wire                     timer0_clk_sel_osc,
  output wire                     timer0_clk_sel_pin,
  output wire                     timer0_clk_sel_fosc4,
  output wire                     timer0_clk,
  output wire [`CSC_NUM_CHAN-1:0] sense_input_n
);

  reg        sense_enable_q;
  reg        refmode_q;
  reg  [1:0] range_q;
  reg        t0xsrc_q;
  reg  [3:0] chan_q;
  wire       pkg_sync;
  wire       dir_sync;
  wire       acc;
  wire       wr;
  wire       rd;
  wire       hit_main;
  wire       hit_chan;
  wire [7:0] main_rd;
  wire [7:0] wbyte;

  // apb: zero wait states, error on unmapped addresses
  assign acc      = psel && penable;
  assign hit_main = (paddr == `CSC_OFS_MAIN);
  assign hit_chan = (paddr == `CSC_OFS_CHAN);
  assign wr       = acc && pwrite && pstrb[0];
  assign rd       = acc && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = acc && !hit_main && !hit_chan;
  assign wbyte    = pwdata[7:0];

  // direction pin is asynchronous to pclk
  csc_sync u_dir_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (osc_sourcing),
    .sync_out (dir_sync)
  );

  // package strap is a pin too, so it passes its own two-flop synchroniser
  csc_sync u_pkg_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (large_pkg),
    .sync_out (pkg_sync)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_enable_q <= 1'b0;
      refmode_q      <= 1'b0;
      range_q        <= `CSC_RANGE_OFF;
      t0xsrc_q       <= 1'b0;
      chan_q         <= `CSC_CHAN_RESET; // see RULE14
    end else if (wr && hit_main) begin
      // direction bit is not stored, so writes to it vanish see RULE15
      sense_enable_q <= wbyte[`CSC_BIT_ENABLE];
      refmode_q      <= wbyte[`CSC_BIT_REFMODE];
      range_q        <= wbyte[`CSC_RANGE_HI:`CSC_RANGE_LO];
      t0xsrc_q       <= wbyte[`CSC_BIT_T0XSRC];
    end else if (wr && hit_chan) begin
      // stored as written; reserved codes simply connect nothing
      chan_q <= wbyte[3:0];
    end
  end

  assign main_rd = {sense_enable_q, refmode_q, 2'b00, range_q,
                    dir_sync, t0xsrc_q}; // see RULE6

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_main)
        prdata <= {24'h000000, main_rd};
      else if (hit_chan)
        prdata <= {28'h0000000, chan_q}; // see RULE13
      else
        prdata <= 32'h00000000;
    end
  end

  assign sense_enable          = sense_enable_q; // see RULE1
  assign reference_mode_select = refmode_q;      // see RULE2
  assign current_range         = range_q;
  // fixed mode range 00 stops the oscillator see RULE3
  assign osc_run = sense_enable_q &&
                   (refmode_q || (range_q != `CSC_RANGE_OFF));
  // variable mode range 00 runs with no current see RULE4
  assign noise_detect = sense_enable_q && refmode_q &&
                        (range_q == `CSC_RANGE_OFF);
  // nonzero range drives current in either mode see RULE5
  assign charge_current_on = sense_enable_q &&
                             (range_q != `CSC_RANGE_OFF);

  assign timer0_ext_source_select = t0xsrc_q;
  assign timer0_clk_sel_osc   = timer0_clock_select && t0xsrc_q;  // see RULE7
  assign timer0_clk_sel_pin   = timer0_clock_select && !t0xsrc_q; // see RULE7
  assign timer0_clk_sel_fosc4 = !timer0_clock_select;             // see RULE8
  // clock mux is a behavioural stand-in for a glitch-free cell
  assign timer0_clk = !timer0_clock_select ? fosc_div4_clk :
                      (t0xsrc_q ? sense_osc_clk : timer0_ext_clock_pin);

  csc_chan_decode u_chan (
    .enable    (sense_enable_q), // see RULE9
    .large_pkg (pkg_sync),       // see RULE12
    .code      (chan_q),         // see RULE10
    .connect   (sense_input_n)
  );

endmodule // csc_top

/* verif/csc_far.sv */
// Purpose: far-side model of sense oscillator and timer clocks
// Assumes: bench sets the oscillator current direction
// Notes: clocks derived from pclk for brevity
`timescale 1ns/1ps
module csc_far (
  input  wire  pclk,
  input  wire  osc_dir,
  output logic osc_sourcing,
  output logic sense_osc_clk,
  output logic timer0_ext_clock_pin,
  output logic fosc_div4_clk
);
  logic [1:0] div_q = 2'h0;
  always @(posedge pclk) div_q <= div_q + 2'h1;
  assign osc_sourcing = osc_dir;
  assign sense_osc_clk = div_q[0];
  // inverse phase so a wrong mux pick shows
  assign timer0_ext_clock_pin = ~div_q[0];
  assign fosc_div4_clk = div_q[1];
endmodule // csc_far

/* verif/csc_top_chk.sv */
// Purpose: port checks for the sense control block
// Assumes: zero-wait APB slave
// Notes: bound to every csc_top instance
`timescale 1ns/1ps
`include "csc_defs.vh"
module csc_top_chk (
  input wire        pclk, presetn, psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        sense_enable, reference_mode_select, osc_run,
  input wire [1:0]  current_range,
  input wire        noise_detect, charge_current_on, timer0_clk,
  input wire        timer0_clock_select, timer0_ext_source_select,
  input wire        timer0_clk_sel_osc, timer0_clk_sel_pin,
  input wire        timer0_clk_sel_fosc4, fosc_div4_clk,
  input wire        pslverr, sense_osc_clk, timer0_ext_clock_pin,
  input wire [`CSC_NUM_CHAN-1:0] sense_input_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && pwrite && paddr == `CSC_OFS_MAIN;
  endsequence
  sequence s_access;
    psel && penable && pready && pstrb[0];
  endsequence
  sequence s_access_nostrb;
    psel && penable && pready && !pstrb[0];
  endsequence
  a_strb_drop: assert property (s_setup ##1 s_access_nostrb |=>
    $stable(sense_enable) && $stable(current_range))
    else $error("write without strobe applied");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("ready low in access");
  a_err_unmapped: assert property (psel && penable |->
    pslverr == (paddr != `CSC_OFS_MAIN && paddr != `CSC_OFS_CHAN))
    else $error("slave error wrong");
  a_t0_clk_ext: assert property (timer0_clock_select |->
    timer0_clk == (timer0_ext_source_select ? sense_osc_clk :
    timer0_ext_clock_pin)) else $error("timer external clock wrong");
  a_wr_main: assert property (s_setup ##1 s_access |=>
    sense_enable == $past(pwdata[7]) && current_range == $past(pwdata[3:2]))
    else $error("main write not applied");
  a_run_level: assert property (osc_run == (sense_enable &&
    (reference_mode_select || current_range != 2'h0)))
    else $error("oscillator run wrong");
  a_noise_var: assert property (noise_detect == (sense_enable &&
    reference_mode_select && current_range == 2'h0))
    else $error("noise detect wrong");
  a_charge_range: assert property (charge_current_on ==
    (sense_enable && current_range != 2'h0)) else $error("charge wrong");
  a_chan_off: assert property (!sense_enable |-> sense_input_n == 0)
    else $error("channel on while disabled");
  a_chan_one: assert property ($onehot0(sense_input_n))
    else $error("several channels on");
  a_t0_fosc: assert property (!timer0_clock_select |->
    timer0_clk_sel_fosc4 && timer0_clk == fosc_div4_clk)
    else $error("timer clock not fosc4");
  a_t0_ext: assert property (timer0_clock_select |->
    timer0_clk_sel_osc == timer0_ext_source_select &&
    timer0_clk_sel_pin == !timer0_ext_source_select)
    else $error("timer external select wrong");
endmodule // csc_top_chk
bind csc_top csc_top_chk csc_top_chk_i (.*);

/* verif/tb_csc_top.sv */
// Purpose: bench for the sense control block
// Assumes: zero-wait APB slave
// Notes: strap is changed under a second reset; the core follows it through the synchroniser
`timescale 1ns/1ps
`include "csc_defs.vh"
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_csc_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic large_pkg = 1, osc_dir = 0, timer0_clock_select = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat, prdata;
  logic [3:0] pstrb = 4'hF;
  wire pready, pslverr, osc_sourcing, sense_osc_clk, fosc_div4_clk;
  wire timer0_ext_clock_pin, sense_enable, reference_mode_select, osc_run;
  wire noise_detect, charge_current_on, timer0_ext_source_select;
  wire timer0_clk_sel_osc, timer0_clk_sel_pin, timer0_clk_sel_fosc4;
  wire timer0_clk;
  wire [1:0] current_range;
  wire [`CSC_NUM_CHAN-1:0] sense_input_n;
  int n_errors = 0, cmp_count = 0;
  csc_top csc_top_i (.*);
  csc_far csc_far_i (.*);
  always #10 pclk = ~pclk;
  task final_report;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s = 4'hF);
    int i;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin n_errors++; final_report; end
    rdat = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(negedge pclk);
  endtask
  task t_reset;
    apb(0, `CSC_OFS_MAIN, 0); `CHK("main", 32'h0, rdat)
    apb(0, `CSC_OFS_CHAN, 0); `CHK("chan", 32'h0, rdat)
  endtask
  task t_main;
    apb(1, `CSC_OFS_MAIN, 32'hFF); apb(0, `CSC_OFS_MAIN, 0);
    `CHK("mainrd", 32'hCD, rdat)
    apb(1, 12'h008, 32'h0); `CHK("slverr", 1'b1, err)
    apb(0, `CSC_OFS_MAIN, 0); `CHK("kept", 32'hCD, rdat)
    apb(1, `CSC_OFS_MAIN, 32'h0, 4'hE); apb(0, `CSC_OFS_MAIN, 0);
    `CHK("nostrb", 32'hCD, rdat)
    apb(1, `CSC_OFS_MAIN, 32'h44); `CHK("off", 1'b0, osc_run)
  endtask
  task t_modes;
    for (int k = 0; k < 8; k++) begin
      apb(1, `CSC_OFS_MAIN, {24'h0, 1'b1, k[2], 2'b0, k[1:0], 2'b0});
      `CHK("refm", k[2], reference_mode_select)
      `CHK("run", (k[2] || k[1:0] != 0), osc_run)
      `CHK("noise", (k[2] && k[1:0] == 0), noise_detect)
      `CHK("range", k[1:0], current_range)
    end
  endtask
  task t_dir;
    for (int k = 1; k >= 0; k--) begin
      @(posedge pclk) osc_dir <= k[0];
      repeat (4) @(posedge pclk);
      apb(0, `CSC_OFS_MAIN, 0); `CHK("dir", k[0], rdat[1])
    end
  endtask
  task t_t0;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk) timer0_clock_select <= k[1];
      apb(1, `CSC_OFS_MAIN, {31'h0, k[0]});
      `CHK("fosc4", !k[1], timer0_clk_sel_fosc4)
      `CHK("osc", k[1] & k[0], timer0_clk_sel_osc)
      `CHK("pin", k[1] & !k[0], timer0_clk_sel_pin)
    end
  endtask
  task automatic t_chan(input logic big);
    apb(1, `CSC_OFS_MAIN, 32'h80);
    // software never writes the reserved codes 12 to 15
    for (int c = 0; c < `CSC_NUM_CHAN; c++) begin
      apb(1, `CSC_OFS_CHAN, {24'h0, 4'hF, c[3:0]});
      apb(0, `CSC_OFS_CHAN, 0); `CHK("code", {28'h0, c[3:0]}, rdat)
      `CHK("conn", (c < 8 || big && c < 12) ? 12'h1 << c : 12'h0,
           sense_input_n)
    end
    apb(1, `CSC_OFS_MAIN, 0); `CHK("none", 12'h0, sense_input_n)
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset; t_main; t_modes; t_dir; t_t0; t_chan(1);
    @(posedge pclk) begin presetn <= 0; large_pkg <= 0; end
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset; t_chan(0);
    final_report;
  end
endmodule // tb_csc_top
